//--- verilog/sync_mode_ctrl.sv
// How it works
// - Controlled sync only via latched selector; off leaves other modes free.
// - Selector on refuses initiation of every other mode.
// - Moving the selector never aborts an already initiated mode.
// - Controlled sync selected: lamp on and two-bit remote status.
// - Hardwired: momentary buttons pick modes; stop returns any mode to reset but leaves the relay alarm set.
// - Station variant: controlled sync blocks screen direct and sync close.
// - Selected mode always indicated locally and mirrored remotely.
// - At most one mode selected; concurrent second selection rejected.
// - Hardwired: sync transfer accepted only from sync close mode.
// - Station variant: sync transfer accepted directly from idle.
// - Remote commands ORed with local; each mode status reported remotely.
// - Closing one breaker ignores close requests for others; reclose untouched.
// - Selection relays not reset 2 s after reset: alarm, block initiation.
// - Direct or sync close resets unless switch operated within 60 s.
// - After breaker switch, reset if not closed within 60 s.
// - Sync transfer resets if transfer breaker not closed in 30 min.
// - Return to reset once a close command has been issued.
// - Controlled sync resets 15 min after bay selection without close.
// - Drive voltage, angle, frequency and relay-ready condition lamps.
// - Route voltages to instruments only after controlled sync selected.
// - Sync close blocked when voltage present on one side only.
`timescale 1ns/1ps
`default_nettype none
module sync_mode_ctrl
	import sync_mode_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	input  wire logic        CLK_SYS,
	input  wire logic        NRST,
	input  wire logic        STATION_VARIANT,
	input  wire mode_req_t   LOCAL_REQ,
	input  wire mode_req_t   REMOTE_REQ,
	input  wire mode_req_t   SCREEN_REQ,
	input  wire logic        CTRL_SEL_SW,
	input  wire logic        CTRL_CLOSE_SW,
	input  wire bay_t        BAY_SEL,
	input  wire bay_t        CB_SWITCH,
	input  wire bay_t        CB_CLOSED,
	input  wire logic        XFER_CB_CLOSED,
	input  wire logic        VSEL_FB,
	input  wire logic        REF_LIVE,
	input  wire logic        INC_LIVE,
	input  wire cond_t       RELAY_COND,
	output var  mode_ind_t   MODE_LAMPS,
	output var  remote_ind_t REMOTE_IND,
	output var  cond_t       COND_LAMPS,
	output var  logic        VT_ROUTE_EN,
	output var  bay_t        CLOSE_CMD,
	output var  bay_t        ACTIVE_BAY,
	output var  logic        VSEL_ALARM
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [2:0] ones4(input logic [3:0] v);
		logic [2:0] c;
		c = '0;
		for (int i = 0; i < 4; i++) begin
			c = c + {2'h0, v[i]};
		end
		return c;
	endfunction : ones4

	// Rising edges across a bay-wide group of inputs
	function automatic bay_t edge4(input bay_t now, input bay_t was);
		return now & ~was;
	endfunction : edge4

	// Supervision timer has run its full length
	function automatic logic expired(input logic [TMR_W-1:0] t,
		input logic [TMR_W-1:0] lim);
		return t >= lim;
	endfunction : expired

	ctl_state_t q_reg;
	ctl_state_t q_next;

	pins_t      pins_in;
	pins_t      p;
	mode_req_t  src;
	mode_req_t  req_lvl;
	mode_req_t  rise;
	logic [2:0] mode_cnt;
	bay_t       bay_rise;
	bay_t       sw_rise;
	logic       ctrl_on;
	logic       ctrl_edge;
	logic       close_rise;
	logic       go_idle;
	logic       in_ctrl;

	// ****************************************************************
	// Pin capture
	// ****************************************************************
	always_comb begin
		pins_in.station_variant = STATION_VARIANT;
		pins_in.local_req       = LOCAL_REQ;
		pins_in.remote_req      = REMOTE_REQ;
		pins_in.screen_req      = SCREEN_REQ;
		pins_in.ctrl_sel        = CTRL_SEL_SW;
		pins_in.ctrl_close      = CTRL_CLOSE_SW;
		pins_in.bay_sel         = BAY_SEL;
		pins_in.cb_switch       = CB_SWITCH;
		pins_in.cb_closed       = CB_CLOSED;
		pins_in.xfer_closed     = XFER_CB_CLOSED;
		pins_in.vsel_fb         = VSEL_FB;
		pins_in.ref_live        = REF_LIVE;
		pins_in.inc_live        = INC_LIVE;
		pins_in.relay           = RELAY_COND;
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		q_next    = q_reg;
		q_next.s1 = pins_in;
		q_next.s2 = q_reg.s1;
		p         = q_reg.s2;

		// Local source depends on variant, remote always ORed in
		src     = p.station_variant ? p.screen_req : p.local_req;
		req_lvl = mode_req_t'(src | p.remote_req);
		rise    = mode_req_t'(req_lvl & ~q_reg.req_prev);
		q_next.req_prev = req_lvl;

		mode_cnt = ones4({1'b0, rise.direct, rise.sync_close,
			rise.transfer});

		ctrl_on    = p.ctrl_sel;
		ctrl_edge  = ctrl_on ^ q_reg.ctrl_prev;
		close_rise = p.ctrl_close & ~q_reg.close_prev;
		bay_rise   = edge4(p.bay_sel, q_reg.bay_prev);
		sw_rise    = edge4(p.cb_switch, q_reg.sw_prev);
		q_next.ctrl_prev  = ctrl_on;
		q_next.close_prev = p.ctrl_close;
		q_next.bay_prev   = p.bay_sel;
		q_next.sw_prev    = p.cb_switch;

		// Divided tick for all supervision timers
		q_next.tick = 1'b0;
		if (q_reg.div == TICK_W'(TICK_DIV - 1)) begin
			q_next.div  = '0;
			q_next.tick = 1'b1;
		end else begin
			q_next.div = q_reg.div + TICK_W'(1);
		end
		if (q_reg.tick) begin
			q_next.tmr = q_reg.tmr + TMR_W'(1);
		end

		q_next.close_cmd = '0;
		go_idle = 1'b0;

		// ************************************************************
		// Mode selection and supervision
		// ************************************************************
		case (q_reg.st)
			ST_IDLE: begin
				q_next.tmr = '0;
				if (q_reg.vsel_alarm) begin
					q_next.st = ST_IDLE;
				end else if (ctrl_on) begin
					q_next.st = ST_CTRL_WAIT;
				end else if (mode_cnt == ONE_HOT) begin
					if (rise.direct) begin
						q_next.st = ST_DIRECT;
					end else if (rise.sync_close) begin
						q_next.st = ST_SYNC;
					end else if (p.station_variant) begin
						q_next.st = ST_XFER;
					end
				end
			end
			ST_DIRECT, ST_SYNC: begin
				if (ones4(sw_rise) == ONE_HOT) begin
					q_next.st         = ST_CLOSING;
					q_next.bay        = sw_rise;
					q_next.close_sync = (q_reg.st == ST_SYNC);
					q_next.tmr        = '0;
				end else if (q_reg.st == ST_SYNC && rise.transfer &&
					!ctrl_on && mode_cnt == ONE_HOT) begin
					q_next.st  = ST_XFER;
					q_next.tmr = '0;
				end else if (ctrl_edge) begin
					q_next.tmr = '0;
				end else if (expired(q_reg.tmr, SELECT_TICKS)) begin
					go_idle = 1'b1;
				end
			end
			ST_CLOSING: begin
				// Other bays' switches are not looked at here
				if (!q_reg.close_sync) begin
					q_next.close_cmd = q_reg.bay;
					go_idle = 1'b1;
				end else if ((p.ref_live ^ p.inc_live) == 1'b0 &&
					p.ref_live && p.relay.ready) begin
					q_next.close_cmd = q_reg.bay;
					go_idle = 1'b1;
				end else if ((p.cb_closed & q_reg.bay) != '0) begin
					go_idle = 1'b1;
				end else if (expired(q_reg.tmr, CLOSE_TICKS)) begin
					go_idle = 1'b1;
				end
			end
			ST_XFER: begin
				if (p.xfer_closed) begin
					go_idle = 1'b1;
				end else if (expired(q_reg.tmr, XFER_TICKS)) begin
					go_idle = 1'b1;
				end
			end
			ST_CTRL_WAIT: begin
				if (ones4(bay_rise) == ONE_HOT) begin
					q_next.st  = ST_CTRL_BAY;
					q_next.bay = bay_rise;
					q_next.tmr = '0;
				end
			end
			ST_CTRL_BAY: begin
				if (close_rise && p.relay.ready) begin
					q_next.close_cmd = q_reg.bay;
					go_idle = 1'b1;
				end else if ((p.cb_closed & q_reg.bay) != '0) begin
					go_idle = 1'b1;
				end else if (expired(q_reg.tmr, CTRL_TICKS)) begin
					go_idle = 1'b1;
				end
			end
			default: begin
				go_idle = 1'b1;
			end
		endcase

		if (rise.stop) begin
			go_idle = 1'b1;
		end

		// ************************************************************
		// Return to reset and relay feedback watch
		// ************************************************************
		// Return to reset: state, bay and timers cleared, relay watch armed
		if (go_idle) begin
			q_next.st         = ST_IDLE;
			q_next.bay        = '0;
			q_next.close_sync = 1'b0;
			q_next.tmr        = '0;
			q_next.vsel_watch = 1'b1;
			q_next.vsel_cnt   = '0;
		end else if (q_reg.vsel_watch) begin
			if (!p.vsel_fb) begin
				q_next.vsel_watch = 1'b0;
				q_next.vsel_alarm = 1'b0;
			end else if (q_reg.tick) begin
				if (q_reg.vsel_cnt >= VSEL_TICKS - TMR_W'(1)) begin
					q_next.vsel_alarm = 1'b1;
				end else begin
					q_next.vsel_cnt = q_reg.vsel_cnt + TMR_W'(1);
				end
			end
		end

		// ************************************************************
		// Indications
		// ************************************************************
		in_ctrl = (q_next.st == ST_CTRL_WAIT) ||
			(q_next.st == ST_CTRL_BAY);
		q_next.lamps.direct     = (q_next.st == ST_DIRECT) ||
			(q_next.st == ST_CLOSING && !q_next.close_sync);
		q_next.lamps.sync_close = (q_next.st == ST_SYNC) ||
			(q_next.st == ST_CLOSING && q_next.close_sync);
		q_next.lamps.transfer   = (q_next.st == ST_XFER);
		q_next.lamps.ctrl       = in_ctrl;
		q_next.rind.direct      = q_next.lamps.direct;
		q_next.rind.sync_close  = q_next.lamps.sync_close;
		q_next.rind.transfer    = q_next.lamps.transfer;
		q_next.rind.ctrl_dbl    = in_ctrl ? DBL_ON : DBL_OFF;
		q_next.cond             = p.relay;
		q_next.vt_route         = in_ctrl;
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			q_reg               <= '0;
			q_reg.vsel_watch    <= 1'b1;
			q_reg.rind.ctrl_dbl <= DBL_OFF;
			// Relay assumed operated until the synced pin shows it reset
			q_reg.s1.vsel_fb    <= 1'b1;
			q_reg.s2.vsel_fb    <= 1'b1;
		end else begin
			q_reg <= q_next;
		end
	end

	assign MODE_LAMPS  = q_reg.lamps;
	assign REMOTE_IND  = q_reg.rind;
	assign COND_LAMPS  = q_reg.cond;
	assign VT_ROUTE_EN = q_reg.vt_route;
	assign CLOSE_CMD   = q_reg.close_cmd;
	assign ACTIVE_BAY  = q_reg.bay;
	assign VSEL_ALARM  = q_reg.vsel_alarm;

endmodule : sync_mode_ctrl
`default_nettype wire

//--- verilog/sync_mode_pkg.sv
`default_nettype none
package sync_mode_pkg;

	// ****************************************************************
	// Sizes and timing
	// ****************************************************************
	localparam int NBAY          = 4;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_MS       = 100;
	localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TICK_W        = 20;
	localparam int TMR_W         = 16;
	localparam int TICKS_PER_S   = 1000 / TICK_MS;
	localparam int T_VSEL_S      = 2;
	localparam int T_SELECT_S    = 60;
	localparam int T_CLOSE_S     = 60;
	localparam int T_XFER_MIN    = 30;
	localparam int T_CTRL_MIN    = 15;
	localparam int SEC_PER_MIN   = 60;

	localparam logic [TMR_W-1:0] VSEL_TICKS   =
		TMR_W'(T_VSEL_S * TICKS_PER_S);
	localparam logic [TMR_W-1:0] SELECT_TICKS =
		TMR_W'(T_SELECT_S * TICKS_PER_S);
	localparam logic [TMR_W-1:0] CLOSE_TICKS  =
		TMR_W'(T_CLOSE_S * TICKS_PER_S);
	localparam logic [TMR_W-1:0] XFER_TICKS   =
		TMR_W'(T_XFER_MIN * SEC_PER_MIN * TICKS_PER_S);
	localparam logic [TMR_W-1:0] CTRL_TICKS   =
		TMR_W'(T_CTRL_MIN * SEC_PER_MIN * TICKS_PER_S);

	localparam logic [1:0] DBL_OFF = 2'h1;
	localparam logic [1:0] DBL_ON  = 2'h2;
	localparam logic [2:0] ONE_HOT = 3'h1;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef logic [NBAY-1:0] bay_t;

	typedef struct packed {
		logic direct;
		logic sync_close;
		logic transfer;
		logic stop;
	} mode_req_t;

	typedef struct packed {
		logic volt;
		logic angle;
		logic freq;
		logic ready;
	} cond_t;

	typedef struct packed {
		logic direct;
		logic sync_close;
		logic transfer;
		logic ctrl;
	} mode_ind_t;

	typedef struct packed {
		logic       direct;
		logic       sync_close;
		logic       transfer;
		logic [1:0] ctrl_dbl;
	} remote_ind_t;

	typedef struct packed {
		logic      station_variant;
		mode_req_t local_req;
		mode_req_t remote_req;
		mode_req_t screen_req;
		logic      ctrl_sel;
		logic      ctrl_close;
		bay_t      bay_sel;
		bay_t      cb_switch;
		bay_t      cb_closed;
		logic      xfer_closed;
		logic      vsel_fb;
		logic      ref_live;
		logic      inc_live;
		cond_t     relay;
	} pins_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DIRECT,
		ST_SYNC,
		ST_XFER,
		ST_CTRL_WAIT,
		ST_CTRL_BAY,
		ST_CLOSING
	} mode_st_t;

	typedef struct packed {
		pins_t              s1;
		pins_t              s2;
		mode_req_t          req_prev;
		logic               ctrl_prev;
		logic               close_prev;
		bay_t               bay_prev;
		bay_t               sw_prev;
		mode_st_t           st;
		logic               close_sync;
		bay_t               bay;
		logic [TICK_W-1:0]  div;
		logic               tick;
		logic [TMR_W-1:0]   tmr;
		logic [TMR_W-1:0]   vsel_cnt;
		logic               vsel_watch;
		logic               vsel_alarm;
		mode_ind_t          lamps;
		remote_ind_t        rind;
		cond_t              cond;
		logic               vt_route;
		bay_t               close_cmd;
	} ctl_state_t;

endpackage : sync_mode_pkg
`default_nettype wire

//--- sim/cb_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Breakers close two cycles after a command, then trip off again
// ****************************************************************
module cb_model
	import sync_mode_pkg::*;
(
	input  wire logic clk,
	input  wire bay_t close_cmd,
	output wire bay_t cb_closed
);
	bay_t p1_reg = '0;
	bay_t p2_reg = '0;

	assign cb_closed = p2_reg;

	always @(posedge clk) begin
		p1_reg <= close_cmd;
		p2_reg <= p1_reg;
	end
endmodule : cb_model
`default_nettype wire

//--- sim/sync_mode_props.sv
`timescale 1ns/1ps
`default_nettype none
module sync_mode_props
	import sync_mode_pkg::*;
(
	input wire logic        CLK_SYS,
	input wire logic        NRST,
	input wire mode_req_t   LOCAL_REQ,
	input wire cond_t       RELAY_COND,
	input wire mode_ind_t   MODE_LAMPS,
	input wire remote_ind_t REMOTE_IND,
	input wire cond_t       COND_LAMPS,
	input wire logic        VT_ROUTE_EN,
	input wire bay_t        CLOSE_CMD,
	input wire bay_t        ACTIVE_BAY,
	input wire logic        VSEL_ALARM
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);

	one_mode_a: assert property ($onehot0(MODE_LAMPS))
		else $error("two modes lit");
	dbl_code_a: assert property (REMOTE_IND.ctrl_dbl ==
		(MODE_LAMPS.ctrl ? DBL_ON : DBL_OFF)) else $error("bad dbl");
	mirror_a: assert property (REMOTE_IND[4:2] == MODE_LAMPS[3:1])
		else $error("remote mirror wrong");
	route_on_a: assert property (VT_ROUTE_EN == MODE_LAMPS.ctrl)
		else $error("route enable wrong");
	close_once_a: assert property (|CLOSE_CMD |=> CLOSE_CMD == '0)
		else $error("close longer than a pulse");
	close_idle_a: assert property (|CLOSE_CMD |->
		MODE_LAMPS == '0 && ACTIVE_BAY == '0) else $error("not idle");
	close_hot_a: assert property ($onehot0(CLOSE_CMD))
		else $error("two breakers closed");
	stop_idle_a: assert property ($rose(LOCAL_REQ.stop) |->
		##3 MODE_LAMPS == '0) else $error("stop ignored");
	cond_copy_a: assert property ($past(NRST, 1) && $past(NRST, 2)
		&& $past(NRST, 3) |-> COND_LAMPS == $past(RELAY_COND, 3))
		else $error("condition lamps wrong");
	vsel_block_a: assert property (VSEL_ALARM && MODE_LAMPS == '0
		&& ACTIVE_BAY == '0 |=> MODE_LAMPS == '0)
		else $error("mode taken under alarm");

	cover property (MODE_LAMPS.transfer);
	cover property (|CLOSE_CMD);
	cover property (VSEL_ALARM);
endmodule : sync_mode_props

bind sync_mode_ctrl sync_mode_props sync_mode_props_inst (
	.CLK_SYS(CLK_SYS), .NRST(NRST), .LOCAL_REQ(LOCAL_REQ),
	.RELAY_COND(RELAY_COND), .MODE_LAMPS(MODE_LAMPS),
	.REMOTE_IND(REMOTE_IND), .COND_LAMPS(COND_LAMPS),
	.VT_ROUTE_EN(VT_ROUTE_EN), .CLOSE_CMD(CLOSE_CMD),
	.ACTIVE_BAY(ACTIVE_BAY), .VSEL_ALARM(VSEL_ALARM)
);
`default_nettype wire

//--- sim/sync_close_mode_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sync_close_mode_controller_bench
	import sync_mode_pkg::*;
;
	logic clk = 0, nrst = 0, sta = 0, csel = 0, cclose = 0;
	logic xfer = 0, vfb = 1, rl = 0, il = 0, vt, va;
	mode_req_t lreq = '0, rreq = '0, sreq = '0;
	bay_t bsel = '0, cbsw = '0, cbc, cc, ab;
	cond_t rc = '0, cl;
	mode_ind_t ml;
	remote_ind_t ri;
	int n_fail = 0, tests_run = 0, cycles = 0;

	always #50 clk = ~clk;

	cb_model cb_model_inst (.clk(clk), .close_cmd(cc), .cb_closed(cbc));

	sync_mode_ctrl #(.TICK_DIV(4)) sync_mode_ctrl_inst (
		.CLK_SYS(clk), .NRST(nrst), .STATION_VARIANT(sta),
		.LOCAL_REQ(lreq), .REMOTE_REQ(rreq), .SCREEN_REQ(sreq),
		.CTRL_SEL_SW(csel), .CTRL_CLOSE_SW(cclose), .BAY_SEL(bsel),
		.CB_SWITCH(cbsw), .CB_CLOSED(cbc), .XFER_CB_CLOSED(xfer),
		.VSEL_FB(vfb), .REF_LIVE(rl), .INC_LIVE(il), .RELAY_COND(rc),
		.MODE_LAMPS(ml), .REMOTE_IND(ri), .COND_LAMPS(cl),
		.VT_ROUTE_EN(vt), .CLOSE_CMD(cc), .ACTIVE_BAY(ab),
		.VSEL_ALARM(va)
	);

	task close_out;
		$display("checks %0d, failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	always @(posedge clk) begin
		cycles++;
		if (cycles > 45000) begin
			n_fail++;
			close_out();
		end
	end

	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task ck(input bit ok, input string m);
		tests_run++;
		if (!ok) begin
			n_fail++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : ck

	// Press and release one button set, then let the state settle
	task tap(input int s, input mode_req_t m);
		case (s)
		0: lreq = m;
		1: rreq = m;
		default: sreq = m;
		endcase
		cyc(2);
		lreq = '0;
		rreq = '0;
		sreq = '0;
		cyc(3);
	endtask : tap

	task wait_close(input bay_t b);
		int i;
		for (i = 0; i < 20 && cc == '0; i++)
			cyc(1);
		ck(cc === b, "close command wrong");
	endtask : wait_close

	task t_vsel;
		vfb = 1;
		cyc(110);
		ck(va === 1'b1, "no relay alarm");
		tap(0, 4'h8);
		ck(ml === 4'h0, "mode taken under alarm");
		vfb = 0;
		cyc(5);
		ck(va === 1'b0, "alarm stuck");
	endtask : t_vsel

	task t_direct;
		tap(0, 4'h8);
		ck(ml === 4'h8 && ri === 5'h11, "direct lamp");
		tap(1, 4'h4);
		ck(ml === 4'h8, "second mode taken");
		cbsw = 4'h2;
		wait_close(4'h2);
		cbsw = '0;
		cyc(2);
		ck(ml === 4'h0 && ab === 4'h0, "not idle");
		tap(0, 4'h4);
		tap(0, 4'h1);
		ck(ml === 4'h0, "stop ignored");
	endtask : t_direct

	task t_xfer;
		tap(0, 4'h2);
		ck(ml === 4'h0, "transfer from idle");
		rl = 1;
		rc = 4'h1;
		tap(0, 4'h4);
		ck(cl === 4'h1, "condition lamps");
		cbsw = 4'h1;
		wait_close(4'h0);
		il = 1;
		wait_close(4'h1);
		cbsw = '0;
		tap(0, 4'h4);
		tap(0, 4'h2);
		ck(ml === 4'h2, "transfer refused");
		xfer = 1;
		cyc(5);
		ck(ml === 4'h0, "transfer kept");
		xfer = 0;
	endtask : t_xfer

	task t_ctrl;
		sta = 1;
		cyc(3);
		tap(2, 4'h2);
		ck(ml === 4'h2, "direct transfer refused");
		tap(1, 4'h1);
		ck(ml === 4'h0, "remote stop ignored");
		csel = 1;
		cyc(5);
		ck(ml === 4'h1 && ri === 5'h02 && vt === 1'b1, "ctrl");
		tap(2, 4'h8);
		ck(ml === 4'h1, "screen direct taken");
		bsel = 4'h4;
		cyc(5);
		bsel = 4'h1;
		cyc(5);
		ck(ab === 4'h4, "bay replaced");
		bsel = '0;
		csel = 0;
		rc = 4'hF;
		cyc(5);
		ck(ml === 4'h1 && cl === 4'hF, "ctrl aborted");
		cclose = 1;
		wait_close(4'h4);
		cclose = 0;
		sta = 0;
		cyc(3);
	endtask : t_ctrl

	task t_tmo;
		tap(1, 4'h4);
		cyc(2300);
		ck(ml === 4'h4, "early reset");
		cyc(200);
		ck(ml === 4'h0, "no select timeout");
	endtask : t_tmo

	task t_ctrl_tmo;
		csel = 1;
		cyc(5);
		bsel = 4'h2;
		cyc(5);
		bsel = '0;
		csel = 0;
		cyc(35900);
		ck(ml === 4'h1 && ab === 4'h2, "early ctrl reset");
		cyc(200);
		ck(ml === 4'h0 && ab === 4'h0, "no ctrl timeout");
	endtask : t_ctrl_tmo

	initial begin
		cyc(8);
		nrst = 1;
		cyc(3);
		t_vsel();
		t_direct();
		t_xfer();
		t_ctrl();
		t_tmo();
		t_ctrl_tmo();
		close_out();
	end
endmodule : sync_close_mode_controller_bench
`default_nettype wire
